// ### hdl/slc_lane_cfg.v
// Behaviour
// - Phase align bit drives serializer alignment, applied in facility loopback.
// - Signal detect has threshold enable and threshold level fields.
// - DC couple and CMV termination bits select termination mode.
// - Hysteresis has own enable and separate level field.
// - Swing code steps 50 mV from 0.4 V to 1.1 V, clamped.
// - One bit switches fixed 3 dB de-emphasis on or off.
// - Electrical idle bit forces output below 30 mV.
// - Both LPI enables hand buffer activity to the PCS.
// - Separate tx and rx polarity flips invert serial data.
// - Multirate lane offers four rates; 100 Mbps by oversampling.
// - Multirate lane held in reset until enable and both resets released.
// - Equipment loopback routes serializer to deserializer, output still active.
// - Facility loopback routes recovered clock and data to serializer.
// - Gigabit lane held in reset until enable and both resets released.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "slc_map.vh"
module slc_lane_cfg #(
    parameter LANES = 2
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Wishbone slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    output reg              wb_err_o,
    // PCS quiet requests
    input  wire [LANES-1:0] pcs_lpi_tx_quiet_i,
    input  wire [LANES-1:0] pcs_lpi_rx_quiet_i,
    // Per-lane macro controls, one bit or field per lane kind
    output reg  [LANES-1:0] lane_active_o,
    output reg  [LANES-1:0] pll_cal_go_o,
    output reg  [LANES-1:0] equipment_loopback_on_o,
    output reg  [LANES-1:0] facility_loopback_on_o,
    output reg  [LANES-1:0] serializer_phase_align_on_o,
    output reg  [LANES-1:0] tx_buffer_on_o,
    output reg  [LANES-1:0] rx_buffer_on_o,
    output reg  [LANES-1:0] tx_polarity_flip_o,
    output reg  [LANES-1:0] rx_polarity_flip_o,
    output reg  [LANES-1:0] tx_electrical_idle_o,
    output reg  [LANES-1:0] tx_deemphasis_on_o,
    output reg  [4*LANES-1:0] output_swing_setting_o,
    output reg  [LANES-1:0] multirate_oversample_o,
    output reg  [32*LANES-1:0] ib_cfg_o,
    output reg  [32*LANES-1:0] pll_cfg_o,
    output reg  [32*LANES-1:0] common_cfg_o,
    output reg  [32*LANES-1:0] misc_cfg_o
);

// ----------------------------------------
// Register storage: lane 0 gigabit, lane 1 multirate
// ----------------------------------------
reg  [31:0] common_r [0:LANES-1];
reg  [31:0] ib_r     [0:LANES-1];
reg  [31:0] ob_r     [0:LANES-1];
reg  [31:0] pll_r    [0:LANES-1];
reg  [31:0] misc_r   [0:LANES-1];
reg  [LANES-1:0] fsm_on_d_r;
wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
wire        lane_sel = wb_adr_i[5];
wire [7:0]  loc      = {3'h0, wb_adr_i[4:0]};
wire        mapped   = (wb_adr_i[1:0] == 2'h0) & (wb_adr_i < 8'h34 | wb_adr_i == `SLC_STATUS)
                       & (loc <= `SLC_G_MISC | wb_adr_i == `SLC_STATUS);
wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

// ----------------------------------------
// Bus access
// ----------------------------------------
reg  [31:0] rd_nxt;
integer k;
always @* begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == `SLC_STATUS) begin
        for (k = 0; k < LANES; k = k + 1) begin
            rd_nxt[k]     = lane_active_o[k];
            rd_nxt[8 + k] = pll_cal_go_o[k];
        end
    end else begin
        case (loc)
            `SLC_G_COMMON: rd_nxt = common_r[lane_sel];
            `SLC_G_IB:     rd_nxt = ib_r[lane_sel];
            `SLC_G_OB_SER: rd_nxt = ob_r[lane_sel];
            `SLC_G_PLL:    rd_nxt = pll_r[lane_sel];
            `SLC_G_MISC:   rd_nxt = misc_r[lane_sel];
            default:       rd_nxt = 32'h0000_0000;
        endcase
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_err_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= req & mapped;
        wb_err_o <= req & ~mapped;
        wb_dat_o <= (req & mapped & ~wb_we_i) ? rd_nxt : 32'h0000_0000;
    end
end

// ----------------------------------------
// Per-lane registers and derived controls
// ----------------------------------------
genvar g;
generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
        wire wr = req & mapped & wb_we_i & (lane_sel == g) & (wb_adr_i != `SLC_STATUS);
        wire [31:0] swing_raw = ob_r[g] >> `SLC_O_SWG_LSB;
        // Codes above the top step would overdrive past 1.1 V, so they clamp
        wire [3:0]  swing     = (swing_raw[3:0] > `SLC_SWING_MAX) ? `SLC_SWING_MAX
                                                                  : swing_raw[3:0];
        wire lpi_own = misc_r[g][`SLC_X_TX_LPI] & misc_r[g][`SLC_X_RX_LPI];
        wire active  = common_r[g][`SLC_C_LANE_ON] & common_r[g][`SLC_C_MACRO_SYSTEM_RESET]
                       & ~misc_r[g][`SLC_X_LANE_RST];
        always @(posedge clk_i) begin
            if (rst_i) begin
                common_r[g] <= `SLC_RST_COMMON;
                ib_r[g]     <= `SLC_RST_IB;
                ob_r[g]     <= `SLC_RST_OB_SER;
                pll_r[g]    <= `SLC_RST_PLL;
                misc_r[g]   <= `SLC_RST_MISC;
            end else if (wr) begin
                // Every field read/write per lane
                case (loc)
                    `SLC_G_COMMON: common_r[g] <= ((common_r[g] & ~wmask) | (wb_dat_i & wmask))
                                                  & `SLC_MASK_COMMON;
                    `SLC_G_IB:     ib_r[g]     <= ((ib_r[g] & ~wmask) | (wb_dat_i & wmask))
                                                  & `SLC_MASK_IB;
                    `SLC_G_OB_SER: ob_r[g]     <= ((ob_r[g] & ~wmask) | (wb_dat_i & wmask))
                                                  & `SLC_MASK_OB_SER;
                    `SLC_G_PLL:    pll_r[g]    <= ((pll_r[g] & ~wmask) | (wb_dat_i & wmask))
                                                  & `SLC_MASK_PLL;
                    `SLC_G_MISC:   misc_r[g]   <= ((misc_r[g] & ~wmask) | (wb_dat_i & wmask))
                                                  & `SLC_MASK_MISC;
                    default:       common_r[g] <= common_r[g];
                endcase
            end
        end
        always @(posedge clk_i) begin
            if (rst_i) begin
                lane_active_o[g]               <= 1'b0;
                pll_cal_go_o[g]                <= 1'b0;
                fsm_on_d_r[g]                  <= 1'b0;
                equipment_loopback_on_o[g]     <= 1'b0;
                facility_loopback_on_o[g]      <= 1'b0;
                serializer_phase_align_on_o[g] <= 1'b0;
                tx_buffer_on_o[g]              <= 1'b0;
                rx_buffer_on_o[g]              <= 1'b0;
                tx_polarity_flip_o[g]          <= 1'b0;
                rx_polarity_flip_o[g]          <= 1'b0;
                tx_electrical_idle_o[g]        <= 1'b0;
                tx_deemphasis_on_o[g]          <= 1'b0;
                output_swing_setting_o[4*g +: 4] <= 4'h0;
                multirate_oversample_o[g]      <= 1'b0;
                ib_cfg_o[32*g +: 32]           <= 32'h0000_0000;
                pll_cfg_o[32*g +: 32]          <= 32'h0000_0000;
                common_cfg_o[32*g +: 32]       <= 32'h0000_0000;
                misc_cfg_o[32*g +: 32]         <= 32'h0000_0000;
            end else begin
                lane_active_o[g] <= active;
                fsm_on_d_r[g]    <= pll_r[g][`SLC_P_FSM_ON];
                // Calibration starts on the FSM enable rising while the macro system reset bit is set, whatever the lane reset bit
                pll_cal_go_o[g]  <= pll_r[g][`SLC_P_FSM_ON] & ~fsm_on_d_r[g]
                                    & common_r[g][`SLC_C_MACRO_SYSTEM_RESET];
                // Facility loopback wins if software breaks the exclusion
                facility_loopback_on_o[g]  <= active & common_r[g][`SLC_C_FLOOP];
                equipment_loopback_on_o[g] <= active & common_r[g][`SLC_C_ELOOP]
                                              & ~common_r[g][`SLC_C_FLOOP];
                serializer_phase_align_on_o[g] <= ob_r[g][`SLC_O_ALIGN]
                                                  & common_r[g][`SLC_C_FLOOP];
                // Under LPI the PCS quiet requests gate the buffers
                tx_buffer_on_o[g] <= active & ~(lpi_own & pcs_lpi_tx_quiet_i[g]);
                rx_buffer_on_o[g] <= active & ~(lpi_own & pcs_lpi_rx_quiet_i[g]);
                tx_polarity_flip_o[g] <= misc_r[g][`SLC_X_TX_INV];
                rx_polarity_flip_o[g] <= misc_r[g][`SLC_X_RX_INV];
                tx_electrical_idle_o[g] <= ob_r[g][`SLC_O_IDLE];
                tx_deemphasis_on_o[g]   <= ob_r[g][`SLC_O_DEEMPH];
                output_swing_setting_o[4*g +: 4] <= swing;
                // Fiber at 100 Mbps uses the oversampling CDR path
                multirate_oversample_o[g] <= misc_r[g][`SLC_X_CDR_OS]
                                             & ib_r[g][`SLC_I_FIBER];
                ib_cfg_o[32*g +: 32]     <= ib_r[g];
                pll_cfg_o[32*g +: 32]    <= pll_r[g];
                common_cfg_o[32*g +: 32] <= common_r[g];
                misc_cfg_o[32*g +: 32]   <= misc_r[g];
            end
        end
    end
endgenerate

endmodule

// ### hdl/slc_map.vh
`ifndef SLC_MAP_VH
`define SLC_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SLC_G_COMMON   8'h00
`define SLC_G_IB       8'h04
`define SLC_G_OB_SER   8'h08
`define SLC_G_PLL      8'h0c
`define SLC_G_MISC     8'h10
`define SLC_M_COMMON   8'h20
`define SLC_M_IB       8'h24
`define SLC_M_OB_SER   8'h28
`define SLC_M_PLL      8'h2c
`define SLC_M_MISC     8'h30
`define SLC_STATUS     8'h3c
// ----------------------------------------
// Common register fields
// ----------------------------------------
`define SLC_C_LANE_ON  0
`define SLC_C_MACRO_SYSTEM_RESET  1
`define SLC_C_ELOOP    2
`define SLC_C_FLOOP    3
`define SLC_C_QUARTER_RATE_SEL    4
`define SLC_C_HALF_RATE_SEL    5
// ----------------------------------------
// Input buffer fields
// ----------------------------------------
`define SLC_I_FIBER    0
`define SLC_I_DET_ON   1
`define SLC_I_DET_LSB  4
`define SLC_I_EQG_LSB  8
`define SLC_I_CRN_LSB  12
`define SLC_I_OFFS     16
`define SLC_I_DCC      17
`define SLC_I_CMV      18
`define SLC_I_HYST     19
`define SLC_I_HLV_LSB  20
// ----------------------------------------
// Output buffer / serializer fields
// ----------------------------------------
`define SLC_O_SWG_LSB  0
`define SLC_O_SLP_LSB  4
`define SLC_O_DEEMPH   8
`define SLC_O_IDLE     9
`define SLC_O_ALIGN    10
// ----------------------------------------
// PLL fields
// ----------------------------------------
`define SLC_P_CAL_LSB  0
`define SLC_P_FSM_ON   8
`define SLC_P_ROT_FRQ  9
`define SLC_P_ROT_DIR  10
`define SLC_P_ROT_ON   11
// ----------------------------------------
// Misc fields
// ----------------------------------------
`define SLC_X_LANE_RST 0
`define SLC_X_CDR_OS   1
`define SLC_X_TX_LPI   2
`define SLC_X_RX_LPI   3
`define SLC_X_TX_INV   4
`define SLC_X_RX_INV   5
`define SLC_X_CDR_LSB  8
// ----------------------------------------
// Reset values, writable-bit masks and swing limit
// ----------------------------------------
`define SLC_RST_COMMON 32'h0000_0000
`define SLC_RST_IB     32'h0005_0000
`define SLC_RST_OB_SER 32'h0000_000c
`define SLC_RST_PLL    32'h0000_0000
`define SLC_RST_MISC   32'h0000_0001
`define SLC_MASK_COMMON 32'h0000_003f
`define SLC_MASK_IB     32'h00ff_ff13
`define SLC_MASK_OB_SER 32'h0000_07ff
`define SLC_MASK_PLL    32'h0000_0fff
`define SLC_MASK_MISC   32'h0000_033f
`define SLC_SWING_MAX   4'he
`endif

// ### bench/slc_pcs_model.sv
`timescale 1ns/10ps
// ----
// Attached PCS: raises quiet requests while the bench says the link idles
// ----
module slc_pcs_model #(parameter LANES = 2) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [LANES-1:0] idle_req_i,
    output reg  [LANES-1:0] tx_quiet_o,
    output reg  [LANES-1:0] rx_quiet_o
);
    // Receive sleeps a cycle after transmit, so the two requests disagree
    // briefly and a mixed-up direction in the block shows
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_quiet_o <= {LANES{1'b0}};
            rx_quiet_o <= {LANES{1'b0}};
        end else begin
            tx_quiet_o <= idle_req_i;
            rx_quiet_o <= tx_quiet_o & idle_req_i;
        end
    end
endmodule

// ### bench/slc_lane_cfg_props.sv
`timescale 1ns/10ps
// ----
// Port relations of the lane configuration block
// ----
module slc_props #(parameter LANES = 2) (
    input wire               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o,
    input wire [7:0]         wb_adr_i,
    input wire [31:0]        wb_dat_o,
    input wire [LANES-1:0]   pcs_lpi_tx_quiet_i, lane_active_o, pll_cal_go_o,
    input wire [LANES-1:0]   equipment_loopback_on_o, facility_loopback_on_o,
    input wire [LANES-1:0]   serializer_phase_align_on_o, tx_buffer_on_o,
    input wire [LANES-1:0]   tx_polarity_flip_o, multirate_oversample_o,
    input wire [4*LANES-1:0] output_swing_setting_o,
    input wire [32*LANES-1:0] ib_cfg_o, pll_cfg_o, common_cfg_o, misc_cfg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    sequence s_once; (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o); endsequence
    AST_ANSWER: assert property (s_take |=> s_once)
        else $error("bus answer not a single pulse");
    AST_BADADR: assert property (s_take ##0 (wb_adr_i[1:0] != 2'h0) |=> wb_err_o)
        else $error("misaligned access accepted");
    AST_DATIDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    for (genvar g = 0; g < LANES; g++) begin : gl
        wire [31:0] c = common_cfg_o[32*g+:32];
        wire [31:0] m = misc_cfg_o[32*g+:32];
        wire act = c[0] & c[1] & ~m[0];
        AST_ACTIVE: assert property (lane_active_o[g] == act)
            else $error("lane active wrong");
        AST_FLOOP: assert property (facility_loopback_on_o[g] == (act & c[3]))
            else $error("facility loopback wrong");
        AST_ELOOP: assert property (equipment_loopback_on_o[g] == (act & c[2] & ~c[3]))
            else $error("equipment loopback wrong");
        AST_ALIGN: assert property (serializer_phase_align_on_o[g] |-> c[3])
            else $error("phase align outside facility loopback");
        AST_SWING: assert property (output_swing_setting_o[4*g+:4] <= 4'he)
            else $error("swing above top step");
        AST_CALGO: assert property (pll_cal_go_o[g] |-> (pll_cfg_o[32*g+8] && c[1]) ##1 !pll_cal_go_o[g])
            else $error("calibration start wrong");
        AST_LPI: assert property (tx_buffer_on_o[g] == (lane_active_o[g] & ~(m[2] & m[3] & $past(pcs_lpi_tx_quiet_i[g]))))
            else $error("tx buffer activity wrong");
        AST_FLIP: assert property (tx_polarity_flip_o[g] == m[4])
            else $error("tx flip wrong");
        AST_OSMP: assert property (multirate_oversample_o[g] == (m[1] & ib_cfg_o[32*g]))
            else $error("oversampling wrong");
    end
endmodule
bind slc_lane_cfg slc_props #(.LANES(LANES)) u_props (.*);

// ### bench/slc_lane_cfg_tb.sv
`timescale 1ns/10ps
`include "slc_map.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module slc_lane_cfg_tb;
    reg          clk_i = 0, rst_i = 1, req = 0, we = 0, e;
    reg  [7:0]   adr = 0;
    reg  [3:0]   sel = 0;
    reg  [1:0]   idle = 0;
    reg  [31:0]  wdat = 0, rdat, x, sh [0:15];
    wire [31:0]  dat;
    wire         ack, err;
    wire [1:0]   tq, rq, act, go, el, fl, al, tbo, rbo, tp, rp, ei, de, os;
    wire [7:0]   sw;
    wire [63:0]  ibc, plc, cmc, msc;
    integer      miscompares = 0, cmp_count = 0, gon = 0, i, g, k;
    always #2 clk_i = ~clk_i;
    always @(negedge clk_i) gon = gon + go[0] + go[1];
    slc_lane_cfg #(.LANES(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err), .pcs_lpi_tx_quiet_i(tq),
        .pcs_lpi_rx_quiet_i(rq), .lane_active_o(act), .pll_cal_go_o(go),
        .equipment_loopback_on_o(el), .facility_loopback_on_o(fl),
        .serializer_phase_align_on_o(al), .tx_buffer_on_o(tbo), .rx_buffer_on_o(rbo),
        .tx_polarity_flip_o(tp), .rx_polarity_flip_o(rp), .tx_electrical_idle_o(ei),
        .tx_deemphasis_on_o(de), .output_swing_setting_o(sw), .multirate_oversample_o(os),
        .ib_cfg_o(ibc), .pll_cfg_o(plc), .common_cfg_o(cmc), .misc_cfg_o(msc));
    slc_pcs_model #(.LANES(2)) pcs (.clk_i(clk_i), .rst_i(rst_i), .idle_req_i(idle),
        .tx_quiet_o(tq), .rx_quiet_o(rq));
    // ----
    // Expectations
    // ----
    function [31:0] ev(input [7:0] a, input r);
        case (a[4:0])
            5'h00: ev = r ? `SLC_RST_COMMON : `SLC_MASK_COMMON;
            5'h04: ev = r ? `SLC_RST_IB : `SLC_MASK_IB;
            5'h08: ev = r ? `SLC_RST_OB_SER : `SLC_MASK_OB_SER;
            5'h0c: ev = r ? `SLC_RST_PLL : `SLC_MASK_PLL;
            default: ev = r ? `SLC_RST_MISC : `SLC_MASK_MISC;
        endcase
    endfunction
    function av(input l); av = sh[8*l][0] & sh[8*l][1] & ~sh[8*l+4][0]; endfunction
    function [3:0] sm(input [3:0] v); sm = (v > 4'he) ? 4'he : v; endfunction
    function lp(input l); lp = sh[8*l+4][2] & sh[8*l+4][3]; endfunction
    task give_verdict;
        begin
            if (miscompares == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task bus(input w, input [7:0] a, input [3:0] s, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            req <= 1;
            we <= w;
            adr <= a;
            sel <= s;
            wdat <= d;
            // Ack is sampled at the rising edge, before that edge updates it
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (n < 64 && (ack | err) !== 1'b1);
            if ((ack | err) !== 1'b1) begin miscompares++; give_verdict; end
            rdat = dat;
            e = err;
            req <= 0;
        end
    endtask
    // Shadow keeps only the bytes that were enabled and the bits that exist
    task wr(input [7:0] a, input [3:0] s, input [31:0] d);
        reg [31:0] b;
        begin
            b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & ev(a, 0);
            bus(1, a, s, d);
            sh[a[5:2]] = (sh[a[5:2]] & ~b) | (d & b);
        end
    endtask
    task chk_out;
        begin
            @(negedge clk_i);
            `CHK({cmc, ibc, plc, msc}, {sh[8], sh[0], sh[9], sh[1], sh[11], sh[3], sh[12], sh[4]})
            `CHK(act, {av(1), av(0)})
            `CHK(sw, {sm(sh[10][3:0]), sm(sh[2][3:0])})
            `CHK(de, {sh[10][8], sh[2][8]})
            `CHK(ei, {sh[10][9], sh[2][9]})
            `CHK(rp, {sh[12][5], sh[4][5]})
            `CHK({tbo, rbo}, {av(1) & ~(lp(1) & tq[1]), av(0) & ~(lp(0) & tq[0]), av(1) & ~(lp(1) & rq[1]), av(0) & ~(lp(0) & rq[0])})
            `CHK(os, {sh[12][1] & sh[9][0], sh[4][1] & sh[1][0]})
            `CHK(fl, {av(1) & sh[8][3], av(0) & sh[0][3]})
            @(posedge clk_i);
        end
    endtask
    initial begin
        x = $urandom(29791);
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        for (i = 0; i < 10; i++) begin
            k = i / 5 * 32 + i % 5 * 4;
            bus(0, k[7:0], 4'hf, 0);
            `CHK(rdat, ev(k[7:0], 1))
            sh[k[5:2]] = ev(k[7:0], 1);
        end
        for (i = 0; i < 300; i++) begin
            k = $urandom % 10;
            k = k / 5 * 32 + k % 5 * 4;
            idle <= 2'($urandom);
            x = $urandom;
            if (k % 32 == 4) x[19] = x[19] & ~x[16];
            if (k % 32 == 0) x[2] = x[2] & ~x[3];
            wr(k[7:0], 4'($urandom), x);
            bus(0, k[7:0], 4'h0, 0);
            `CHK(rdat, sh[k[5:2]])
            chk_out;
        end
        bus(1, 8'h14, 4'hf, 32'hffffffff);
        `CHK({e, rdat}, 33'h1_0000_0000)
        bus(0, 8'h22, 4'hf, 0);
        `CHK({e, rdat}, 33'h1_0000_0000)
        bus(0, 8'h3c, 4'hf, 0);
        `CHK({e, rdat[1:0]}, {1'b0, act})
        for (g = 0; g < 2; g++) begin
            k = g * 32;
            // Lane 0 gets 200, lane 1 gets 60 with the 1 Gbps rotation and rate bits
            x = g ? 32'h43c : 32'hc8;
            wr(k[7:0] + 8'hc, 4'hf, x);
            wr(k[7:0] + 8'h4, 4'hf, 32'h0005_0000);
            wr(k[7:0], 4'hf, 32'h1);
            wr(k[7:0] + 8'h10, 4'hf, 32'h0);
            chk_out;
            i = gon;
            wr(k[7:0], 4'hf, g ? 32'h13 : 32'h3);
            wr(k[7:0] + 8'hc, 4'hf, x | 32'h100);
            repeat (4) @(posedge clk_i);
            `CHK(gon, i + 1)
            idle <= 2'h3;
            wr(k[7:0] + 8'h4, 4'hf, 32'h0006_0001);
            wr(k[7:0] + 8'h10, 4'hf, 32'h23e);
            wr(k[7:0] + 8'h8, 4'hf, 32'h70f);
            wr(k[7:0], 4'hf, g ? 32'h1b : 32'hb);
            chk_out;
        end
        give_verdict;
    end
endmodule
